// ---- include/seisw_pkg.sv ----
package seisw_pkg;

    // Bus framing.
    localparam logic [3:0] DEV_CODE      = 4'ha;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] PAGE_LAST     = 4'hf;
    localparam int         ADDR_W        = 9;
    localparam int         PAGE_W        = 4;
    localparam int         PAGE_BYTES    = 16;

    // Commit path toward the memory array.
    localparam int         WORD_W        = ADDR_W + 8;
    localparam int         FIFO_DEPTH    = 8;

    // Internal write period, rounded up to whole clock cycles.
    localparam int         INTERNAL_WRITE_TIME_NS = 4_000_000;
    localparam int         MCLK_PERIOD_NS         = 8;
    localparam int         INTERNAL_WRITE_CYCLES  =
        (INTERNAL_WRITE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int         TIMER_W                = 20;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_WORD = 3'h3,
        ST_DATA = 3'h2,
        ST_READ = 3'h6,
        ST_WAIT = 3'h7
    } seisw_phase_type;

endpackage : seisw_pkg

// ---- rtl/seisw_fifo.sv ----
`timescale 1ns/1ps
module seisw_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } seisw_fifo_state_type;

    seisw_fifo_state_type q;
    seisw_fifo_state_type next_q;
    logic                 push;
    logic                 pop;

    // The count is one bit wider than the index, so a full buffer is told apart from an empty one.
    assign in_ready  = (q.cnt < (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];

    always_comb begin
        next_q = q;
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        if (push) begin
            next_q.mem[q.wr] = in_data;
            next_q.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            next_q.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : seisw_fifo

// ---- rtl/seisw_slave.sv ----
`timescale 1ns/1ps
module seisw_slave
    import seisw_pkg::*;
#(
    parameter int WRITE_CYCLES = seisw_pkg::INTERNAL_WRITE_CYCLES
) (
    // Clock and reset.
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // Two-wire bus pins.
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    // Strap and protect pins.
    input  wire logic                        strap_addr_lo,
    input  wire logic                        strap_addr_hi,
    input  wire logic                        write_protect,
    // Memory array read side.
    output logic [seisw_pkg::ADDR_W-1:0]     rd_addr,
    input  wire logic [7:0]                  rd_data,
    // Memory array commit side.
    output logic                             mem_wr_valid,
    input  wire logic                        mem_wr_ready,
    output logic [seisw_pkg::ADDR_W-1:0]     mem_wr_addr,
    output logic [7:0]                       mem_wr_data,
    // Status.
    output logic                             busy
);
    import seisw_pkg::*;

    typedef struct packed {
        logic [2:0]                     scl_p;
        logic [2:0]                     sda_p;
        logic [1:0]                     strap_m;
        logic [1:0]                     strap;
        logic                           wp_m;
        logic                           wp;
        seisw_phase_type                st;
        logic [3:0]                     cnt;
        logic                           armed;
        logic [7:0]                     sr;
        logic [7:0]                     tx;
        logic                           ack;
        logic                           a8;
        logic [ADDR_W-1:0]              ptr;
        logic                           wp_block;
        logic                           pend;
        logic [PAGE_BYTES-1:0][7:0]     pbuf;
        logic [PAGE_BYTES-1:0]          vmask;
        logic                           busy;
        logic [TIMER_W-1:0]             timer;
        logic                           drain;
        logic [PAGE_W-1:0]              didx;
        logic                           sda_oe;
        logic                           sda_out;
        logic                           wr_valid;
        logic [WORD_W-1:0]              wr_word;
    } seisw_state_type;

    seisw_state_type   q;
    seisw_state_type   next_q;
    logic              rise;
    logic              fall;
    logic              start;
    logic              stop;
    logic              sda;
    logic              match;
    logic              f_in_valid;
    logic              f_in_ready;
    logic [WORD_W-1:0] f_in_data;
    logic              f_out_valid;
    logic              f_out_ready;
    logic [WORD_W-1:0] f_out_data;

    // Bit 1 is the settled sample and bit 2 its previous value; bit 0 is never read here.
    assign sda   = q.sda_p[1];
    assign rise  = q.scl_p[1] && !q.scl_p[2];
    assign fall  = !q.scl_p[1] && q.scl_p[2];
    assign start = q.scl_p[1] && q.scl_p[2] && q.sda_p[2] && !sda;
    assign stop  = q.scl_p[1] && q.scl_p[2] && !q.sda_p[2] && sda;
    assign match = (q.sr[7:4] == DEV_CODE)
                && (q.sr[3] == q.strap[1])
                && (q.sr[2] == q.strap[0]);

    assign f_in_data   = {q.ptr[ADDR_W-1:PAGE_W], q.didx, q.pbuf[q.didx]};
    assign f_out_ready = !q.wr_valid || mem_wr_ready;

    assign sda_out      = q.sda_out;
    assign sda_oe       = q.sda_oe;
    assign rd_addr      = q.ptr;
    assign mem_wr_valid = q.wr_valid;
    assign mem_wr_addr  = q.wr_word[WORD_W-1:8];
    assign mem_wr_data  = q.wr_word[7:0];
    assign busy         = q.busy;

    seisw_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb begin
        next_q     = q;
        f_in_valid = 1'b0;
        next_q.scl_p   = {q.scl_p[1:0], scl_in};
        next_q.sda_p   = {q.sda_p[1:0], sda_in};
        // Pins float low through internal pull-downs; each is still sampled through two flops before use.
        next_q.strap_m = {strap_addr_hi, strap_addr_lo};
        next_q.strap   = q.strap_m;
        next_q.wp_m    = write_protect;
        next_q.wp      = q.wp_m;

        // Hand the page to the array one valid byte at a time; a full FIFO stalls the walk.
        if (q.drain) begin
            f_in_valid = q.vmask[q.didx];
            if (!q.vmask[q.didx] || f_in_ready) begin
                next_q.didx = q.didx + 1'b1;
                if (q.didx == PAGE_LAST) begin
                    next_q.drain = 1'b0;
                    next_q.vmask = '0;
                end
            end
        end
        if (q.timer != '0) begin
            next_q.timer = q.timer - 1'b1;
        end else if (!q.drain) begin
            next_q.busy = 1'b0;
        end

        if (f_out_ready) begin
            next_q.wr_valid = f_out_valid;
            if (f_out_valid) begin
                next_q.wr_word = f_out_data;
            end
        end

        if (start) begin
            next_q.st     = ST_DEV;
            next_q.cnt    = CNT_ZERO;
            next_q.armed  = 1'b0;
            next_q.sda_oe = 1'b0;
            // A repeated START abandons a half-built page, but never one being committed.
            if (!q.busy) begin
                next_q.pend  = 1'b0;
                next_q.vmask = '0;
            end
        end else if (stop) begin
            next_q.st     = ST_IDLE;
            next_q.sda_oe = 1'b0;
            next_q.pend   = 1'b0;
            if (q.pend && !q.busy) begin
                next_q.busy  = 1'b1;
                next_q.timer = TIMER_W'(WRITE_CYCLES);
                next_q.drain = 1'b1;
                next_q.didx  = '0;
            end
        end else if (q.st != ST_IDLE && q.st != ST_WAIT) begin
            if (rise && q.cnt != BIT_ACK) begin
                next_q.sr = {q.sr[6:0], sda};
            end
            if (rise && q.cnt == BIT_ACK) begin
                next_q.ack = !sda;
            end
            if (rise) begin
                next_q.armed = 1'b1;
            end
            // The clock fall that closes a START carries no bit.
            // Counting it would decide on the address one bit early.
            if (fall && q.armed) begin
                next_q.sda_oe = 1'b0;
                next_q.cnt    = q.cnt + 1'b1;
                if (q.cnt == BIT_LAST) begin
                    unique case (q.st)
                        ST_DEV: begin
                            if (match && !q.busy) begin
                                next_q.sda_oe = 1'b1;
                                next_q.a8     = q.sr[1];
                                next_q.st     = q.sr[0] ? ST_READ : ST_WORD;
                            end else begin
                                next_q.st = ST_WAIT;
                            end
                        end
                        ST_WORD: begin
                            next_q.ptr    = {q.a8, q.sr};
                            next_q.sda_oe = 1'b1;
                            next_q.st     = ST_DATA;
                        end
                        ST_DATA: begin
                            if (q.wp_block) begin
                                next_q.st = ST_WAIT;
                            end else begin
                                next_q.sda_oe = 1'b1;
                                next_q.pbuf[q.ptr[PAGE_W-1:0]]  = q.sr;
                                next_q.vmask[q.ptr[PAGE_W-1:0]] = 1'b1;
                                next_q.ptr[PAGE_W-1:0] = q.ptr[PAGE_W-1:0] + 1'b1;
                                next_q.pend   = 1'b1;
                            end
                        end
                        ST_READ: begin
                            next_q.ptr = q.ptr + 1'b1;
                        end
                        default: begin
                            next_q.st = ST_WAIT;
                        end
                    endcase
                end else if (q.cnt == BIT_ACK) begin
                    next_q.cnt = CNT_ZERO;
                    if (q.st == ST_DATA && !q.pend) begin
                        next_q.wp_block = q.wp;
                    end
                    if (q.st == ST_READ) begin
                        if (q.ack) begin
                            next_q.tx     = rd_data;
                            next_q.sda_oe = !rd_data[7];
                        end else begin
                            next_q.st = ST_WAIT;
                        end
                    end
                end else if (q.st == ST_READ) begin
                    next_q.sda_oe = !q.tx[6];
                    next_q.tx     = {q.tx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q       <= '0;
            q.scl_p <= 3'h7;
            q.sda_p <= 3'h7;
        end else begin
            q <= next_q;
        end
    end

    property p_drive_low_only;
        @(posedge mclk) disable iff (!rst_n)
        !sda_out;
    endproperty
    a_drive_low_only: assert property (p_drive_low_only)
        else $error("Data pin output level is not low.");

    property p_edge_timing;
        @(posedge mclk) disable iff (!rst_n)
        $changed(sda_oe) |-> $past(fall || start || stop);
    endproperty
    a_edge_timing: assert property (p_edge_timing)
        else $error("Data drive changed away from a clock fall.");

    property p_start_wakes;
        @(posedge mclk) disable iff (!rst_n)
        start |=> (q.st == ST_DEV) && (q.cnt == CNT_ZERO) && !sda_oe;
    endproperty
    a_start_wakes: assert property (p_start_wakes)
        else $error("START did not begin address reception.");

    property p_addr_ack;
        @(posedge mclk) disable iff (!rst_n)
        (q.st == ST_DEV) && fall && (q.cnt == BIT_LAST) && !start && !stop
        |=> (sda_oe == ($past(match) && !$past(q.busy)));
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("Slave address acknowledge is wrong.");

    property p_busy_quiet;
        @(posedge mclk) disable iff (!rst_n)
        busy |-> !sda_oe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("Data pin driven during internal write.");

    property p_stop_launch;
        @(posedge mclk) disable iff (!rst_n)
        stop && q.pend && !q.busy
        |=> busy ##1 (busy && q.timer == TIMER_W'(WRITE_CYCLES - 1));
    endproperty
    a_stop_launch: assert property (p_stop_launch)
        else $error("Internal write did not start with full count.");

    property p_wp_reject;
        @(posedge mclk) disable iff (!rst_n)
        (q.st == ST_DATA) && q.wp_block && fall && (q.cnt == BIT_LAST)
        && !start && !stop |=> !sda_oe && (q.st == ST_WAIT) && !q.pend;
    endproperty
    a_wp_reject: assert property (p_wp_reject)
        else $error("Protected data byte was acknowledged.");

    property p_page_wrap;
        @(posedge mclk) disable iff (!rst_n)
        (q.st == ST_DATA) && !q.wp_block && fall && (q.cnt == BIT_LAST)
        && !start && !stop
        |=> (q.ptr[ADDR_W-1:PAGE_W] == $past(q.ptr[ADDR_W-1:PAGE_W]))
            && (q.ptr[PAGE_W-1:0] == $past(q.ptr[PAGE_W-1:0]) + 1'b1);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("Page pointer did not step within the page.");

endmodule : seisw_slave

// ---- test/seisw_master.sv ----
`timescale 1ns/1ps
module seisw_master (
    // Clock of the bench.
    input  wire logic mclk,
    // Two-wire bus.
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // The bus idles with both lines released to their pull-ups.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // Data only moves while the clock is low, so no false frame is ever made.
    task automatic put_bit(input logic b, output logic seen);
        tick(2);
        sda_low = ~b;
        tick(3);
        scl = 1'b1;
        tick(3);
        seen = sda;
        tick(2);
        scl = 1'b0;
    endtask : put_bit

    // Works both from an idle bus and as a repeated frame start.
    task automatic start();
        tick(2);
        sda_low = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(5);
        sda_low = 1'b1;
        tick(5);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        tick(2);
        sda_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(5);
        sda_low = 1'b0;
        tick(10);
    endtask : stop

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : wr_byte

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(~ack, s);
    endtask : rd_byte
endmodule : seisw_master

// ---- test/seisw_slave_tb.sv ----
`timescale 1ns/1ps
module seisw_slave_tb;
    import seisw_pkg::*;
    localparam int WR = 200;
    logic              mclk, rst_n, scl, m_low, sda_oe, sda_out;
    logic              hi, lo, wp, ready, valid, busy, prev_scl, prev_oe, ack;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [7:0]        rd_data, wr_data, d;
    logic [7:0]        mem [512];
    int                num_errors, total_checks, cycles, busy_len, commits;
    wire logic         sda = ~(m_low | sda_oe);

    assign rd_data = mem[rd_addr];

    seisw_slave #(.WRITE_CYCLES(WR)) i_seisw_slave (.mclk(mclk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_addr_lo(lo), .strap_addr_hi(hi), .write_protect(wp),
        .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr_valid(valid),
        .mem_wr_ready(ready), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .busy(busy));
    seisw_master i_seisw_master (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic frame(input logic [7:0] a, output logic ok);
        i_seisw_master.start();
        i_seisw_master.wr_byte(a, ok);
    endtask : frame

    // The slow array keeps words in the buffer after the timer, so wait for both.
    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy !== 1'b0 || valid !== 1'b0) && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        check(n < 5000, 1);
    endtask : wait_idle

    // Array side: accepts one word in sixteen cycles, so the buffer fills.
    always @(negedge mclk) ready <= (cycles % 16) == 0;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            finish_test();
        end
        if (busy === 1'b1) busy_len++;
        if (valid === 1'b1 && ready === 1'b1) begin
            mem[wr_addr] = wr_data;
            commits++;
        end
        if (rst_n && scl && prev_scl) check(sda_oe, prev_oe);
        if (sda_oe === 1'b1) check(sda_out, 0);
        prev_scl <= scl;
        prev_oe <= sda_oe;
    end

    initial begin
        rst_n = 1'b0;
        hi = 1'b0;
        lo = 1'b1;
        wp = 1'b0;
        prev_scl = 1'b1;
        prev_oe = 1'b0;
        for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h3c;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        check(sda_oe, 0);
        check(busy, 0);
        i_seisw_master.wr_byte(8'ha4, ack);
        check(ack, 0);
        end_test("no_start");

        // Match, code, strap and ninth bit cases; only the first two match.
        for (int i = 0; i < 6; i++) begin
            frame(i == 0 ? 8'ha4 : i == 1 ? 8'ha6 : i == 2 ? 8'ha0 :
                  i == 3 ? 8'hac : i == 4 ? 8'hb4 : 8'h24, ack);
            i_seisw_master.stop();
            check(ack, i < 2);
        end
        check(busy, 0);
        end_test("address");

        frame(8'ha6, ack);
        i_seisw_master.wr_byte(8'h3e, ack);
        check(ack, 1);
        for (int k = 0; k < 18; k++) begin
            i_seisw_master.wr_byte(8'h10 + 8'(k), ack);
            check(ack, 1);
        end
        busy_len = 0;
        commits = 0;
        i_seisw_master.stop();
        frame(8'ha6, ack);
        check(ack, 0);
        check(busy, 1);
        i_seisw_master.stop();
        wait_idle();
        check(busy_len >= WR, 1);
        check(commits, 16);
        for (int j = 0; j < 16; j++) check(mem[{1'b1, 4'h3, j[3:0]}], 8'h12 + j);
        check(mem[9'h140], 8'h40 ^ 8'h3c);
        check(mem[9'h12f], 8'h2f ^ 8'h3c);
        frame(8'ha6, ack);
        check(ack, 1);
        i_seisw_master.stop();
        end_test("page_write");

        frame(8'ha4, ack);
        i_seisw_master.wr_byte(8'h05, ack);
        i_seisw_master.wr_byte(8'h5a, ack);
        i_seisw_master.stop();
        wait_idle();
        frame(8'ha4, ack);
        i_seisw_master.wr_byte(8'h05, ack);
        frame(8'ha5, ack);
        check(ack, 1);
        i_seisw_master.rd_byte(1'b1, d);
        check(d, 8'h5a);
        i_seisw_master.rd_byte(1'b0, d);
        check(d, 8'h06 ^ 8'h3c);
        i_seisw_master.stop();
        end_test("byte_write_read");

        wp = 1'b1;
        frame(8'ha4, ack);
        i_seisw_master.wr_byte(8'h20, ack);
        i_seisw_master.wr_byte(8'h77, ack);
        check(ack, 0);
        i_seisw_master.stop();
        repeat (20) @(negedge mclk);
        check(busy, 0);
        check(mem[9'h020], 8'h20 ^ 8'h3c);
        wp = 1'b0;
        end_test("protect");

        frame(8'ha4, ack);
        i_seisw_master.wr_byte(8'h30, ack);
        i_seisw_master.wr_byte(8'h99, ack);
        i_seisw_master.stop();
        check(busy, 1);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        check(busy, 0);
        frame(8'ha4, ack);
        check(ack, 1);
        i_seisw_master.stop();
        wait_idle();
        end_test("reset");

        lo = 1'b0;
        frame(8'ha0, ack);
        i_seisw_master.stop();
        check(ack, 1);
        frame(8'ha4, ack);
        i_seisw_master.stop();
        check(ack, 0);
        end_test("straps_low");
        finish_test();
    end
endmodule : seisw_slave_tb
